// ---- design/ardc_rate_cal.sv ----
// rate divider, sinc decimator and per-channel offset/gain correction
// assumes modulator bit streams arrive synchronous to MCLK and are
// sampled on each sampling clock enable; config ports are static
// between writes.
// the offset and gain words are read live at each result, so a host
// that changes them mid-period sees the new words on the next result;
// only the two rate codes are latched, because they steer the
// counters and a half-applied ratio would give one bad period.
// limitation: one modulator bit per sampling enable; a multi-bit
// quantiser would need a wider integrator in each lane.
`timescale 1ns/10ps
module ardc_rate_cal
    import ardc_pkg::*;
#(
    parameter int NCH = `ARDC_NCH,
    parameter int DW = `ARDC_DATA_W
) (
    input wire logic MCLK,                       // master clock 25 MHz
    input wire logic RST_N,                      // async reset, low
    input wire logic CFG_WE,                     // load config fields
    input wire logic [1:0] CFG_PRESCALE,         // prescale code
    input wire logic [2:0] CFG_OSR,              // oversampling select
    input wire logic [NCH*DW-1:0] CFG_OFFSET,    // offset words
    input wire logic [NCH*DW-1:0] CFG_GAIN,      // gain words
    input wire logic [NCH-1:0] MOD_BIT,          // modulator bits
    input wire logic OUT_READY,                  // receiver ready
    output logic [1:0] PRESCALE_CODE,            // active prescale
    output logic [2:0] OSR_CODE,                 // active select
    output logic MODULATOR_CLOCK,                // prescaled enable
    output logic SAMPLING_CLOCK,                 // sample enable
    output logic OUTPUT_RATE_CLOCK,              // result enable
    output logic DATA_READY_STROBE_N,            // ready pulse, low
    output logic OUT_VALID,                      // frame valid
    output logic [NCH*DW-1:0] OUT_DATA,          // corrected frame
    output logic OVERRUN                         // frame dropped
);
    // ------------------------------------------------------------
    // configuration fields
    // ------------------------------------------------------------
    logic [1:0] prescale_select;
    logic [2:0] oversampling_select;
    logic restart;

    // a write always restarts counters so no period mixes ratios;
    // restart holds the clear for a second edge so that the first
    // period is measured from a clean zero on every counter, at the
    // cost of one extra cycle before the first result after a write
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            prescale_select <= `ARDC_PRE_RESET;
            oversampling_select <= `ARDC_OSR_RESET;
            restart <= 1'b0;
        end else begin
            restart <= CFG_WE;
            if (CFG_WE) begin
                prescale_select <= CFG_PRESCALE;
                oversampling_select <= CFG_OSR;
            end
        end
    end
    // the active codes are echoed so a host can read back what runs
    assign PRESCALE_CODE = prescale_select;
    assign OSR_CODE = oversampling_select;

    // ------------------------------------------------------------
    // clock dividers as one-cycle enables
    // ------------------------------------------------------------
    // the three stages chain like ripple dividers, but every stage
    // runs on MCLK and only advances on the enable of the stage
    // before it, so all enables are aligned and one MCLK cycle wide, except MODULATOR_CLOCK, which stays high at prescale code 0
    logic [2:0] pre_cnt;
    logic [1:0] mod_cnt;
    // sized for the largest ratio; smaller ratios use the low bits
    logic [11:0] osr_cnt;
    logic [3:0] osr_log2;
    logic [3:0] pre_log2;

    // code to log2 of the ratio: both tables are plain powers of two
    assign pre_log2 = {2'h0, prescale_select};
    assign osr_log2 = {1'b0, oversampling_select} +
        4'(`ARDC_OSR_BASE_LOG2);
    wire [2:0] pre_last = 3'((1 << pre_log2) - 1);
    wire [11:0] osr_last = 12'((1 << osr_log2) - 1);
    wire modulator_clock = (pre_cnt == pre_last);
    wire sampling_clock = modulator_clock && (mod_cnt == 2'h3);
    wire output_rate_clock = sampling_clock && (osr_cnt == osr_last);

    // counters cleared on restart so the new ratio applies whole; the
    // chain wraps on its own, so no compare against a total is needed
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            pre_cnt <= '0;
            mod_cnt <= '0;
            osr_cnt <= '0;
        end else if (CFG_WE || restart) begin
            pre_cnt <= '0;
            mod_cnt <= '0;
            osr_cnt <= '0;
        end else begin
            pre_cnt <= modulator_clock ? 3'h0 : pre_cnt + 3'h1;
            if (modulator_clock) mod_cnt <= mod_cnt + 2'h1;
            if (sampling_clock)
                osr_cnt <= output_rate_clock ? 12'h000 : osr_cnt + 12'h001;
        end
    end
    // enables leave as they are decoded; registering them would
    // shift them one cycle off the counters that they describe
    assign MODULATOR_CLOCK = modulator_clock;
    assign SAMPLING_CLOCK = sampling_clock;
    assign OUTPUT_RATE_CLOCK = output_rate_clock;

    // ------------------------------------------------------------
    // sinc decimation and correction, one lane per channel
    // ------------------------------------------------------------
    ardc_stream_if corr_if ();
    logic [NCH*DW-1:0] corr_frame;
    logic corr_valid;

    // each lane integrates ones over a whole period and dumps at the
    // result enable; the dump sees the last sample through the adder
    // so a period holds exactly the ratio's count of samples
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_lane
            // boxcar integrate-and-dump: sinc1 nulls every fD multiple
            logic [12:0] acc;
            logic signed [DW-1:0] raw;
            logic signed [DW-1:0] corrected;
            // per-lane words, ch0 in the low bits of each bus
            wire signed [DW-1:0] ofs = CFG_OFFSET[ch*DW +: DW];
            wire signed [DW:0] gain_s = {1'b0, CFG_GAIN[ch*DW +: DW]};
            wire [12:0] dump = acc + {12'h000, MOD_BIT[ch]};
            // bipolar result: 2*ones - N, scaled up to full width
            wire signed [DW-1:0] bip = DW'(signed'({1'b0, dump, 1'b0})
                - signed'({2'b00, osr_last} + 15'h0001));
            // full scale is 2**(DW-1), one past the largest positive
            // word, so the scaled value keeps one spare bit; cutting it
            // to DW bits would turn an all-ones period into minus full
            // scale before offset and gain are applied
            wire signed [DW:0] scaled = (DW+1)'(bip) <<<
                (DW - 1 - osr_log2);
            wire signed [DW:0] with_ofs = scaled + (DW+1)'(ofs);
            // gain is unsigned with DW-1 fraction bits: 1.0 is the top
            // bit alone, so words above it amplify and below attenuate
            wire signed [2*DW+1:0] prod = with_ofs * gain_s;
            wire signed [DW+2:0] prod_q = (DW+3)'(prod >>> `ARDC_GAIN_FRAC);
            wire signed [DW-1:0] sat_hi = {1'b0, {(DW-1){1'b1}}};
            wire signed [DW-1:0] sat_lo = {1'b1, {(DW-1){1'b0}}};
            // saturate so a large gain word clips instead of wrapping
            wire signed [DW-1:0] clipped =
                (prod_q > (DW+3)'(sat_hi)) ? sat_hi :
                (prod_q < (DW+3)'(sat_lo)) ? sat_lo : DW'(prod_q);

            // a write clears the integrator but keeps the last word
            // on the output, so a host reading late still sees a frame
            always_ff @(posedge MCLK or negedge RST_N) begin
                if (!RST_N) begin
                    acc <= '0;
                    corrected <= '0;
                end else if (CFG_WE || restart) begin
                    acc <= '0;
                end else if (output_rate_clock) begin
                    acc <= '0;
                    corrected <= clipped;
                end else if (sampling_clock) begin
                    acc <= dump;
                end
            end
            assign corr_frame[ch*DW +: DW] = corrected;
        end
    endgenerate

    // ------------------------------------------------------------
    // result strobe, ready pulse and buffering
    // ------------------------------------------------------------
    // a result landing on a write belongs to the old ratio and is
    // suppressed, so every frame handed to the buffer matches the live codes
    wire result_take = output_rate_clock && !CFG_WE;

    // a result that finds the buffer full is dropped and flagged; the
    // flag is a level the host can poll, cleared by the next frame
    // that gets in, so it reports only the most recent result
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            corr_valid <= 1'b0;
            DATA_READY_STROBE_N <= 1'b1;
            OVERRUN <= 1'b0;
        end else begin
            corr_valid <= result_take;
            DATA_READY_STROBE_N <= !result_take;
            if (corr_valid && !corr_if.ready) OVERRUN <= 1'b1;
            else if (corr_valid) OVERRUN <= 1'b0;
        end
    end
    // the interface carries the lanes' registered words unchanged
    assign corr_if.valid = corr_valid;
    assign corr_if.data = corr_frame;

    // two frames of slack: the host may take a frame up to about two
    // result periods late before anything is lost
    ardc_skid_buf #(
        .DEPTH(2)
    ) u_buf (
        .clk(MCLK),
        .rst_n(RST_N),
        .up(corr_if),
        .out_valid(OUT_VALID),
        .out_data(OUT_DATA),
        .out_ready(OUT_READY)
    );
endmodule : ardc_rate_cal

// ---- design/ardc_defines.svh ----
// constants for the converter rate divider and calibration block
// assumes inclusion by bare name from package and modules
`ifndef ARDC_DEFINES_SVH
`define ARDC_DEFINES_SVH
`define ARDC_MOD_DIV 4
`define ARDC_OSR_RESET 3'h3
`define ARDC_PRE_RESET 2'h0
`define ARDC_OSR_BASE_LOG2 5
`define ARDC_DATA_W 24
`define ARDC_NCH 3
`define ARDC_GAIN_FRAC 23
`define ARDC_DR_PULSE_CYC 1
`endif

// ---- design/ardc_pkg.sv ----
// types shared by the rate divider block and its output buffer
// assumes ardc_defines.svh sits beside it
`include "ardc_defines.svh"
package ardc_pkg;
    typedef logic signed [`ARDC_DATA_W-1:0] ardc_sample_t;
    typedef logic [`ARDC_NCH*`ARDC_DATA_W-1:0] ardc_frame_t;
    typedef enum logic [1:0] {
        ARDC_BUF_EMPTY = 2'h1,
        ARDC_BUF_HOLD = 2'h2
    } ardc_buf_state_t;
endpackage : ardc_pkg

// ---- design/ardc_stream_if.sv ----
// valid/ready stream carrying one corrected three-channel frame
// assumes a single clock shared by both ends
`timescale 1ns/10ps
interface ardc_stream_if;
    import ardc_pkg::*;
    logic valid;
    ardc_frame_t data;
    logic ready;
    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface : ardc_stream_if

// ---- design/ardc_skid_buf.sv ----
// two-entry buffer for corrected frames
// assumes one clock; upstream honours ready, downstream may stall
`timescale 1ns/10ps
module ardc_skid_buf
    import ardc_pkg::*;
#(
    parameter int DEPTH = 2
) (
    input wire logic clk,           // master clock
    input wire logic rst_n,         // async reset, active low
    ardc_stream_if.sink up,         // frames from the corrector
    output logic out_valid,         // frame waiting
    output ardc_frame_t out_data,   // frame at head
    input wire logic out_ready      // receiver takes frame
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    ardc_frame_t mem [DEPTH];
    logic [$clog2(DEPTH)-1:0] wr_ptr;
    logic [$clog2(DEPTH)-1:0] rd_ptr;
    logic [$clog2(DEPTH):0] count;
    logic [$clog2(DEPTH)-1:0] next_rd;
    wire push = up.valid && up.ready;
    wire pop = out_valid && out_ready;
    // entries left behind the head once this cycle's pop is done
    wire [$clog2(DEPTH):0] kept = count - {{$clog2(DEPTH){1'b0}}, pop};
    // a frame arriving with nothing kept becomes the head at once,
    // otherwise the head register would show a stale slot for a cycle
    wire head_from_up = push && (kept == '0);

    // honest flags so back-pressure reaches the corrector
    assign up.ready = (count != ($clog2(DEPTH)+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign next_rd = pop ? rd_ptr + 1'b1 : rd_ptr;

    // head is read out of a register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_data <= '0;
        end else begin
            out_data <= head_from_up ? up.data : mem[next_rd];
        end
    end

    // storage has no reset; the pointers say what is valid
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= up.data;
        end
    end

    // pointers and fill count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            rd_ptr <= next_rd;
            count <= count + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
        end
    end
endmodule : ardc_skid_buf

// ---- sim/ardc_host_model.sv ----
// host model that drains corrected frames from the block
// assumes it shares MCLK with the block; the bench sets stall
`timescale 1ns/10ps
module ardc_host_model (
    input wire logic clk, // master clock
    input wire logic rst_n, // reset, low
    input wire logic stall, // hold off
    input wire logic out_valid, // frame waiting
    input wire logic [71:0] out_data, // head frame
    output logic out_ready, // taking
    output int pops, // frames taken
    output logic [71:0] last // last frame
);
    // ready trails stall by one cycle, like a polling host
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_ready <= 1'b0;
            pops <= 0;
            last <= 72'h0;
        end else begin
            out_ready <= ~stall;
            if (out_valid && out_ready) begin
                pops <= pops + 1;
                last <= out_data;
            end
        end
    end
endmodule : ardc_host_model

// ---- sim/ardc_rate_cal_sva.sv ----
// timing checks on the rate divider, top ports only
// assumes one clock MCLK and async low reset RST_N
`timescale 1ns/10ps
module ardc_rate_cal_sva (
    input wire logic MCLK, // clock
    input wire logic RST_N, // reset
    input wire logic CFG_WE, // load
    input wire logic [1:0] CFG_PRESCALE, // code in
    input wire logic [2:0] CFG_OSR, // code in
    input wire logic [1:0] PRESCALE_CODE, // active
    input wire logic [2:0] OSR_CODE, // active
    input wire logic MODULATOR_CLOCK, // enable
    input wire logic SAMPLING_CLOCK, // enable
    input wire logic OUTPUT_RATE_CLOCK, // enable
    input wire logic DATA_READY_STROBE_N // strobe
);
    logic [17:0] cnt;
    logic seen_we;
    logic have_ref;
    wire logic ev = CFG_WE | OUTPUT_RATE_CLOCK;
    wire logic [4:0] sh = {2'h0, OSR_CODE} + 5'h05 + {3'h0, PRESCALE_CODE};
    wire logic [17:0] per = 18'h00004 << sh;
    // edges since last result or load; a load adds one restart edge
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt <= 18'h00000;
            seen_we <= 1'b0;
            have_ref <= 1'b0;
        end else begin
            cnt <= ev ? 18'h00001 : cnt + 18'h00001;
            seen_we <= CFG_WE | (seen_we & ~OUTPUT_RATE_CLOCK);
            have_ref <= have_ref | ev;
        end
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    property p_period;
        OUTPUT_RATE_CLOCK && have_ref && !CFG_WE |->
            cnt == per + {17'h00000, seen_we};
    endproperty
    a_period: assert property (p_period)
        else $error("result period wrong");
    property p_bound;
        have_ref |-> cnt <= per + {17'h00000, seen_we};
    endproperty
    a_bound: assert property (p_bound)
        else $error("result overdue");
    property p_strobe;
        OUTPUT_RATE_CLOCK && !CFG_WE |=>
            !DATA_READY_STROBE_N ##1 DATA_READY_STROBE_N;
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("ready pulse wrong");
    property p_cause;
        $fell(DATA_READY_STROBE_N) |-> $past(OUTPUT_RATE_CLOCK);
    endproperty
    a_cause: assert property (p_cause)
        else $error("ready pulse without result");
    property p_modclk;
        PRESCALE_CODE == 2'h0 && !$past(CFG_WE) |-> MODULATOR_CLOCK;
    endproperty
    a_modclk: assert property (p_modclk)
        else $error("modulator enable missing");
    property p_samp;
        disable iff (!RST_N || CFG_WE)
        SAMPLING_CLOCK && PRESCALE_CODE == 2'h0 && !$past(CFG_WE) |=>
            !SAMPLING_CLOCK [*3] ##1 SAMPLING_CLOCK;
    endproperty
    a_samp: assert property (p_samp)
        else $error("sampling spacing wrong");
    property p_load;
        CFG_WE |=> OSR_CODE == $past(CFG_OSR) &&
            PRESCALE_CODE == $past(CFG_PRESCALE);
    endproperty
    a_load: assert property (p_load)
        else $error("codes not loaded");
    property p_rst;
        $rose(RST_N) |-> OSR_CODE == 3'h3 && PRESCALE_CODE == 2'h0;
    endproperty
    a_rst: assert property (p_rst)
        else $error("reset codes wrong");
    c_load: cover property (CFG_WE);
    c_slow: cover property (OUTPUT_RATE_CLOCK && PRESCALE_CODE == 2'h3);
    c_pulse: cover property ($fell(DATA_READY_STROBE_N));
endmodule : ardc_rate_cal_sva
bind ardc_rate_cal ardc_rate_cal_sva u_sva (.MCLK(MCLK), .RST_N(RST_N),
    .CFG_WE(CFG_WE), .CFG_PRESCALE(CFG_PRESCALE), .CFG_OSR(CFG_OSR),
    .PRESCALE_CODE(PRESCALE_CODE), .OSR_CODE(OSR_CODE),
    .MODULATOR_CLOCK(MODULATOR_CLOCK), .SAMPLING_CLOCK(SAMPLING_CLOCK),
    .OUTPUT_RATE_CLOCK(OUTPUT_RATE_CLOCK),
    .DATA_READY_STROBE_N(DATA_READY_STROBE_N));

// ---- sim/ardc_rate_cal_bench.sv ----
// self-checking bench for the rate divider and corrector
// assumes design, host model and checker are compiled first
`timescale 1ns/10ps
module ardc_rate_cal_bench;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic cfg_we = 1'b0;
    logic stall = 1'b0;
    logic [1:0] pre = 2'h0;
    logic [2:0] osr = 3'h0;
    logic [2:0] mbit = 3'h0;
    logic [71:0] off = 72'h0;
    logic [71:0] gain = 72'h0;
    logic [95:0] t;
    logic [95:0] u;
    logic [31:0] seed = 32'hEAF6F557;
    logic rdy, mck, sck, orc, strb_n, vld, ovr;
    logic [1:0] pcode;
    logic [2:0] ocode;
    logic [71:0] odata, last;
    int pops, k, p0;
    int error_cnt = 0;
    int checked = 0;
    ardc_rate_cal dut (.MCLK(mclk), .RST_N(rst_n), .CFG_WE(cfg_we),
        .CFG_PRESCALE(pre), .CFG_OSR(osr), .CFG_OFFSET(off),
        .CFG_GAIN(gain), .MOD_BIT(mbit), .OUT_READY(rdy),
        .PRESCALE_CODE(pcode), .OSR_CODE(ocode), .MODULATOR_CLOCK(mck),
        .SAMPLING_CLOCK(sck), .OUTPUT_RATE_CLOCK(orc),
        .DATA_READY_STROBE_N(strb_n), .OUT_VALID(vld), .OUT_DATA(odata),
        .OVERRUN(ovr));
    ardc_host_model host (.clk(mclk), .rst_n(rst_n), .stall(stall),
        .out_valid(vld), .out_data(odata), .out_ready(rdy), .pops(pops),
        .last(last));
    always #20 mclk = ~mclk;
    task close_out;
        $display("checked %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out
    task chk(input logic [71:0] g, input logic [71:0] e);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task chk_n(input int g, input int e);
        chk(72'(g), 72'(e));
    endtask : chk_n
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // constant bits give full scale either way, then offset and gain
    function logic [23:0] ex(input logic b, input logic [23:0] o, g);
        longint v;
        v = (b ? 64'sh800000 : -64'sh800000) + longint'($signed(o));
        v = (v * longint'(g)) >>> 23;
        if (v > 64'sh7FFFFF) v = 64'sh7FFFFF;
        if (v < -64'sh800000) v = -64'sh800000;
        return v[23:0];
    endfunction : ex
    function logic [71:0] fx();
        return {ex(mbit[2], off[71:48], gain[71:48]),
            ex(mbit[1], off[47:24], gain[47:24]),
            ex(mbit[0], off[23:0], gain[23:0])};
    endfunction : fx
    // bounded wait for the next result enable, counting edges
    task wait_orc(output int n);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (orc !== 1'b1 && n < 20000);
        if (n >= 20000) begin
            error_cnt++;
            close_out();
        end
    endtask : wait_orc
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        @(negedge mclk);
        chk(72'(ocode), 72'h3);
        chk(72'(pcode), 72'h0);
        // every select and prescale code; first case is unity gain
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            t = {xs(), xs(), xs()};
            u = {xs(), xs(), xs()};
            for (int c = 0; c < 3; c++) begin
                off[c*24 +: 24] <= (i == 0) ? 24'h000000 :
                    {{4{t[c*32+19]}}, t[c*32 +: 20]};
                gain[c*24 +: 24] <= (i == 0) ? 24'h800000 :
                    {1'b0, u[c*32 +: 23]};
            end
            mbit <= t[94:92];
            pre <= 2'(3 - i % 4);
            osr <= 3'(i);
            cfg_we <= 1'b1;
            @(posedge mclk);
            cfg_we <= 1'b0;
            wait_orc(k);
            chk_n(k, (4 << (i + 5 + 3 - i % 4)) + 1);
            p0 = pops;
            for (k = 0; k < 8 && pops == p0; k++) @(negedge mclk);
            chk_n(pops, p0 + 1);
            chk(last, fx());
            $display("test %0d done", i);
        end
        // stalled host: third result is dropped, two stay buffered
        @(posedge mclk);
        stall <= 1'b1;
        pre <= 2'h0;
        osr <= 3'h0;
        cfg_we <= 1'b1;
        @(posedge mclk);
        cfg_we <= 1'b0;
        p0 = pops;
        repeat (3) wait_orc(k);
        repeat (3) @(negedge mclk);
        chk(72'(ovr), 72'h1);
        chk_n(pops, p0);
        @(posedge mclk);
        stall <= 1'b0;
        repeat (6) @(negedge mclk);
        chk_n(pops, p0 + 2);
        chk(72'(vld), 72'h0);
        chk(last, fx());
        $display("test overrun done");
        close_out();
    end
endmodule : ardc_rate_cal_bench
